// ### urs_pkg.sv
// Package of constants and types for the receive status reporting block.
package urs_pkg;

  // Receive event field codes, RXCMD bits 5 to 4.
  localparam logic [1:0] EVT_NONE = 2'h0;
  localparam logic [1:0] EVT_ACTIVE = 2'h1;
  localparam logic [1:0] EVT_DISCON = 2'h2;
  localparam logic [1:0] EVT_ACT_ERR = 2'h3;

  // Line condition codes.
  localparam logic [1:0] LC_00 = 2'h0;
  localparam logic [1:0] LC_01 = 2'h1;
  localparam logic [1:0] LC_10 = 2'h2;
  localparam logic [1:0] LC_11 = 2'h3;

  // Transceiver speed select codes.
  localparam logic [1:0] XS_HIGH = 2'h0;
  localparam logic [1:0] XS_LOW = 2'h2;

  // Operating mode select code for chirp.
  localparam logic [1:0] OM_CHIRP = 2'h2;

  // RXCMD field positions.
  localparam int LC_LSB = 0;
  localparam int SUP_LSB = 2;
  localparam int EVT_LSB = 4;
  localparam int ID_BIT = 6;
  localparam int ALT_BIT = 7;

  // Supply indicator slot numbers inside the three-bit supply vector.
  localparam int SUP_SESS_END = 0;
  localparam int SUP_SESSION_VALID = 1;
  localparam int SUP_A_VLD = 2;

  // Supply state encoding values.
  localparam logic [1:0] SUP_BELOW = 2'h0;
  localparam logic [1:0] SUP_ENDRNG = 2'h1;
  localparam logic [1:0] SUP_SESS = 2'h2;
  localparam logic [1:0] SUP_AVALID = 2'h3;

  // Buffer depth and link bus width.
  localparam int BUF_DEPTH = 2;
  localparam int DATA_W = 8;

  // Link side states.
  typedef enum logic [1:0] {
    URS_IDLE = 2'b00,
    URS_TURN = 2'b01,
    URS_SEND = 2'b10
  } urs_link_e;

endpackage : urs_pkg

// ### urs_buf_if.sv
// Interface carrying command bytes between the reporter and its buffer.
`timescale 1ns/1ps
interface urs_buf_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : urs_buf_if

// ### urs_skid_buf.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module urs_skid_buf #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side.
  urs_buf_if.snk in_if,
  // Drain side.
  urs_buf_if.src out_if
);

  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic [W-1:0] rdat_q, rdat_d;
  logic push, pop;

  // Head word is held in a register so the drain side sees flopped data.
  always_comb begin
    push = in_if.valid && (cnt_q != 2'h2);
    pop = out_if.ready && (cnt_q != 2'h0);
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_if.data;
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    rdat_d = mem_d[rd_d];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      rdat_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      rdat_q <= rdat_d;
    end
  end

  // Full and empty come straight from the occupancy count.
  assign in_if.ready = (cnt_q != 2'h2);
  assign out_if.valid = (cnt_q != 2'h0);
  assign out_if.data = rdat_q;

endmodule : urs_skid_buf

// ### urs_rx_status.sv
// Receive status reporter: builds RXCMD bytes and drives them onto the link.
`timescale 1ns/1ps
module urs_rx_status (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration from the control registers.
  input wire logic [1:0] transceiver_speed_select_i,
  input wire logic termination_select_i,
  input wire logic [1:0] operating_mode_select_i,
  input wire logic plus_line_pulldown_i,
  input wire logic minus_line_pulldown_i,
  input wire logic [2:0] rising_irq_enable_i,
  input wire logic [2:0] falling_irq_enable_i,
  input wire logic disconnect_rise_enable_i,
  input wire logic disconnect_fall_enable_i,
  input wire logic fault_polarity_bit_i,
  input wire logic external_supply_indicator_sel_i,
  input wire logic fault_passthrough_bit_i,
  input wire logic supply_drive_enable_i,
  // Analogue front end.
  input wire logic line_plus_i,
  input wire logic line_minus_i,
  input wire logic squelch_i,
  input wire logic hs_diff_rx_i,
  input wire logic [2:0] supply_cmp_i,
  input wire logic ext_fault_i,
  input wire logic id_pin_i,
  input wire logic disconnect_det_i,
  // Receive engine events.
  input wire logic sync_det_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_error_i,
  input wire logic rx_end_i,
  // Link pins.
  input wire logic stp_i,
  output logic dir_o,
  output logic nxt_o,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  // Status out.
  output logic charge_pump_switch_out_o,
  output logic supply_fault_o,
  output logic [1:0] bus_line_condition_o
);

  urs_buf_if #(.W(urs_pkg::DATA_W)) fill_if ();
  urs_buf_if #(.W(urs_pkg::DATA_W)) drain_if ();

  urs_skid_buf #(.W(urs_pkg::DATA_W)) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_if(fill_if),
    .out_if(drain_if)
  );

  // Line condition decode, used for the RXCMD byte and the status port.
  function automatic logic [1:0] line_code(input logic host, input logic [1:0] xs,
                                           input logic ts, input logic [1:0] om,
                                           input logic dp, input logic dm,
                                           input logic sq, input logic hsd);
    logic [1:0] fs;
    fs = {dm, dp};
    line_code = fs;
    if (xs == urs_pkg::XS_HIGH) begin
      // Chirp is set by termination on a peripheral, by mode on a host.
      if (sq) begin
        line_code = urs_pkg::LC_00;
      end else if ((!host && ts) || (host && om == urs_pkg::OM_CHIRP)) begin
        line_code = hsd ? urs_pkg::LC_01 : urs_pkg::LC_10;
      end else begin
        line_code = urs_pkg::LC_01;
      end
    end else if (host && xs == urs_pkg::XS_LOW) begin
      // Low speed K and full speed J both have the plus line high, so the raw pair stands.
      line_code = fs;
    end
    // Peripheral low speed has no own encoding and falls back to full speed.
  endfunction : line_code

  logic host_mode;
  logic [1:0] line_now;
  logic [1:0] sup_now;
  logic fault_q, fault_d;
  logic pump_q, pump_d;
  logic [1:0] line_q, line_d;
  logic [2:0] sup_q, sup_d;
  logic disc_q, disc_d;
  logic rx_act_q, rx_act_d;
  logic err_q, err_d;
  logic pend_q, pend_d;
  logic [1:0] evt_now;
  logic sup_hit;
  logic disc_hit;

  // Role and supply state follow the pull-downs and comparators.
  always_comb begin
    host_mode = plus_line_pulldown_i && minus_line_pulldown_i;
    line_now = line_code(host_mode, transceiver_speed_select_i, termination_select_i,
                         operating_mode_select_i, line_plus_i, line_minus_i, squelch_i,
                         hs_diff_rx_i);
    if (supply_cmp_i[urs_pkg::SUP_A_VLD]) begin
      sup_now = urs_pkg::SUP_AVALID;
    end else if (supply_cmp_i[urs_pkg::SUP_SESSION_VALID]) begin
      sup_now = urs_pkg::SUP_SESS;
    end else if (!supply_cmp_i[urs_pkg::SUP_SESS_END]) begin
      sup_now = urs_pkg::SUP_ENDRNG;
    end else begin
      sup_now = urs_pkg::SUP_BELOW;
    end
    // Supply change counts only through an enabled edge.
    sup_hit = |((supply_cmp_i & ~sup_q & rising_irq_enable_i) |
                (~supply_cmp_i & sup_q & falling_irq_enable_i));
    disc_hit = host_mode && ((disconnect_det_i && !disc_q && disconnect_rise_enable_i) ||
               (!disconnect_det_i && disc_q && disconnect_fall_enable_i));
    // Error outranks disconnect so receive events are never hidden.
    if (err_q) begin
      evt_now = urs_pkg::EVT_ACT_ERR;
    end else if (rx_act_q) begin
      evt_now = urs_pkg::EVT_ACTIVE;
    end else if (host_mode && disc_q) begin
      evt_now = urs_pkg::EVT_DISCON;
    end else begin
      evt_now = urs_pkg::EVT_NONE;
    end
  end

  // Tracked state; line changes, enabled supply and disconnect edges and receive error or end trigger a new RXCMD.
  always_comb begin
    fault_d = fault_passthrough_bit_i ? (ext_fault_i ^ fault_polarity_bit_i) :
              ((ext_fault_i ^ fault_polarity_bit_i) && !supply_cmp_i[urs_pkg::SUP_A_VLD]);
    if (!external_supply_indicator_sel_i) begin
      fault_d = 1'b0;
    end
    pump_d = supply_drive_enable_i && !fault_q;
    line_d = line_now;
    sup_d = supply_cmp_i;
    disc_d = host_mode ? disconnect_det_i : 1'b0;
    rx_act_d = rx_act_q;
    err_d = err_q;
    if (sync_det_i) begin
      rx_act_d = 1'b1;
      err_d = 1'b0;
    end else if (rx_end_i || stp_i) begin
      rx_act_d = 1'b0;
      err_d = 1'b0;
    end
    if (rx_error_i && rx_act_q) begin
      err_d = 1'b1;
    end
    // A pending report stays set until the buffer takes a byte; new hits win.
    pend_d = (pend_q && !fill_if.ready) || sup_hit || disc_hit || (line_now != line_q) ||
             (rx_error_i && rx_act_q) || (rx_end_i && rx_act_q);
  end

  // The byte offered to the buffer is built from the current state.
  always_comb begin
    fill_if.valid = pend_q;
    fill_if.data = '0;
    fill_if.data[urs_pkg::LC_LSB +: 2] = line_q;
    fill_if.data[urs_pkg::SUP_LSB +: 2] = sup_now;
    fill_if.data[urs_pkg::EVT_LSB +: 2] = evt_now;
    fill_if.data[urs_pkg::ID_BIT] = id_pin_i;
    fill_if.data[urs_pkg::ALT_BIT] = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
      pump_q <= 1'b0;
      line_q <= urs_pkg::LC_00;
      sup_q <= 3'h0;
      disc_q <= 1'b0;
      rx_act_q <= 1'b0;
      err_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
      pump_q <= pump_d;
      line_q <= line_d;
      sup_q <= sup_d;
      disc_q <= disc_d;
      rx_act_q <= rx_act_d;
      err_q <= err_d;
      pend_q <= pend_d;
    end
  end

  // Link side: turn-around cycle, then RXCMD bytes or received data.
  urs_pkg::urs_link_e st_q, st_d;
  logic dir_d, nxt_d, oe_n_d;
  logic [7:0] dat_d;
  // Last status byte sent; any idle cycle with the bus turned repeats it, never stale data.
  logic [7:0] last_cmd_q, last_cmd_d;

  always_comb begin
    st_d = st_q;
    dir_d = dir_o;
    nxt_d = 1'b0;
    oe_n_d = data_oe_n_o;
    dat_d = data_o;
    last_cmd_d = last_cmd_q;
    drain_if.ready = 1'b0;
    case (st_q)
      urs_pkg::URS_IDLE: begin
        if (sync_det_i) begin
          dir_d = 1'b1;
          nxt_d = 1'b1;
          st_d = urs_pkg::URS_TURN;
        end else if (drain_if.valid) begin
          dir_d = 1'b1;
          st_d = urs_pkg::URS_TURN;
        end
      end
      urs_pkg::URS_TURN: begin
        oe_n_d = 1'b0;
        dat_d = last_cmd_q;
        st_d = urs_pkg::URS_SEND;
      end
      urs_pkg::URS_SEND: begin
        if (rx_act_q && rx_byte_valid_i && !rx_error_i) begin
          dat_d = rx_byte_i;
          nxt_d = 1'b1;
        end else if (drain_if.valid) begin
          dat_d = drain_if.data;
          last_cmd_d = drain_if.data;
          drain_if.ready = 1'b1;
        end else if (!rx_act_q) begin
          dir_d = 1'b0;
          oe_n_d = 1'b1;
          st_d = urs_pkg::URS_IDLE;
        end else begin
          // With NXT low the link reads the bus as status, so a received byte must not linger.
          dat_d = last_cmd_q;
        end
      end
      default: begin
        st_d = urs_pkg::URS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= urs_pkg::URS_IDLE;
      last_cmd_q <= 8'h00;
      dir_o <= 1'b0;
      nxt_o <= 1'b0;
      data_o <= 8'h00;
      data_oe_n_o <= 1'b1;
      charge_pump_switch_out_o <= 1'b0;
      supply_fault_o <= 1'b0;
      bus_line_condition_o <= urs_pkg::LC_00;
    end else begin
      st_q <= st_d;
      last_cmd_q <= last_cmd_d;
      dir_o <= dir_d;
      nxt_o <= nxt_d;
      data_o <= dat_d;
      data_oe_n_o <= oe_n_d;
      charge_pump_switch_out_o <= pump_q;
      supply_fault_o <= fault_q;
      bus_line_condition_o <= line_q;
    end
  end

endmodule : urs_rx_status

// ### urs_link_model.sv
// Link-side model that collects the bytes the reporter hands over.
`timescale 1ns/1ps
module urs_link_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Link pins as seen from the link.
  input wire logic dir_i,
  input wire logic nxt_i,
  input wire logic [7:0] data_i,
  input wire logic data_oe_n_i,
  output logic stp_o,
  // Collected bytes, nxt flag on top.
  output logic got_o,
  output logic [8:0] got_data_o
);
  logic oe_q;
  logic [7:0] last_q;
  // The link never aborts, so a stray stop cannot hide a fault.
  assign stp_o = 1'b0;
  // A byte counts once the bus has turned; an unchanged status byte is no news.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_q <= 1'b1;
      last_q <= 8'h00;
      got_o <= 1'b0;
      got_data_o <= 9'h000;
    end else begin
      oe_q <= data_oe_n_i;
      got_o <= 1'b0;
      if (dir_i && !data_oe_n_i && !oe_q) begin
        if (nxt_i) begin
          got_o <= 1'b1;
          got_data_o <= {1'b1, data_i};
        end else if (data_i != last_q) begin
          got_o <= 1'b1;
          got_data_o <= {1'b0, data_i};
          last_q <= data_i;
        end
      end
    end
  end
endmodule : urs_link_model

// ### urs_rx_status_assertions.sv
// Concurrent checks on the ports of the receive status reporter.
`timescale 1ns/1ps
module urs_rx_status_checker (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched inputs.
  input wire logic [1:0] transceiver_speed_select_i,
  input wire logic termination_select_i,
  input wire logic plus_line_pulldown_i,
  input wire logic minus_line_pulldown_i,
  input wire logic line_plus_i,
  input wire logic line_minus_i,
  input wire logic squelch_i,
  input wire logic sync_det_i,
  input wire logic rx_error_i,
  input wire logic supply_drive_enable_i,
  // Watched outputs.
  input wire logic dir_o,
  input wire logic nxt_o,
  input wire logic [7:0] data_o,
  input wire logic data_oe_n_o,
  input wire logic charge_pump_switch_out_o,
  input wire logic [1:0] bus_line_condition_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire host = plus_line_pulldown_i && minus_line_pulldown_i;
  wire k_in = line_plus_i && !line_minus_i;
  // Inputs held for three edges, so the registered code has settled.
  sequence periph_fs_k;
    (!host && transceiver_speed_select_i == 2'h1 && termination_select_i && k_in)[*3];
  endsequence
  sequence host_ls_k;
    (host && transceiver_speed_select_i == 2'h2 && termination_select_i && k_in)[*3];
  endsequence
  sequence periph_hs_sq;
    (!host && transceiver_speed_select_i == 2'h0 && !termination_select_i && squelch_i)[*3];
  endsequence
  periph_fs_a: assert property (periph_fs_k |-> bus_line_condition_o == 2'h1)
    else $error("peripheral full speed code wrong");
  host_ls_a: assert property (host_ls_k |-> bus_line_condition_o == 2'h1)
    else $error("host low speed code wrong");
  hs_squelch_a: assert property (periph_hs_sq |-> bus_line_condition_o == 2'h0)
    else $error("squelch code wrong");
  turn_cycle_a: assert property ($rose(dir_o) |-> data_oe_n_o)
    else $error("data driven in turn cycle");
  drive_dir_a: assert property (!data_oe_n_o |-> dir_o)
    else $error("data driven without dir");
  sync_start_a: assert property (sync_det_i && !dir_o |=> dir_o && nxt_o)
    else $error("sync not shown by dir and nxt");
  err_nxt_a: assert property (rx_error_i |-> ##[1:2] !nxt_o)
    else $error("nxt kept after receive error");
  err_cmd_a: assert property (rx_error_i |-> ##[1:12]
    (dir_o && !nxt_o && !data_oe_n_o && data_o[5:4] == urs_pkg::EVT_ACT_ERR))
    else $error("no error status byte");
  pump_off_a: assert property ((!supply_drive_enable_i)[*3] |-> !charge_pump_switch_out_o)
    else $error("charge pump on without request");
endmodule : urs_rx_status_checker

bind urs_rx_status urs_rx_status_checker u_chk (.clk_i, .rst_i, .transceiver_speed_select_i,
  .termination_select_i, .plus_line_pulldown_i, .minus_line_pulldown_i, .line_plus_i,
  .line_minus_i, .squelch_i, .sync_det_i, .rx_error_i, .supply_drive_enable_i, .dir_o, .nxt_o,
  .data_o, .data_oe_n_o, .charge_pump_switch_out_o, .bus_line_condition_o);

// ### urs_rx_status_tb.sv
// Self-checking bench for the receive status reporter.
`timescale 1ns/1ps
module urs_rx_status_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] transceiver_speed_select_i = 2'h1, operating_mode_select_i = 2'h0;
  logic termination_select_i = 1'b1, plus_line_pulldown_i = 1'b0, minus_line_pulldown_i = 1'b0;
  logic [2:0] rising_irq_enable_i = 3'h0, falling_irq_enable_i = 3'h0, supply_cmp_i = 3'h1;
  logic disconnect_rise_enable_i = 1'b0, disconnect_fall_enable_i = 1'b0;
  logic fault_polarity_bit_i = 1'b0, external_supply_indicator_sel_i = 1'b0;
  logic fault_passthrough_bit_i = 1'b0, supply_drive_enable_i = 1'b0, ext_fault_i = 1'b0;
  logic line_plus_i = 1'b0, line_minus_i = 1'b0, squelch_i = 1'b1, hs_diff_rx_i = 1'b0;
  logic id_pin_i = 1'b0, disconnect_det_i = 1'b0, sync_det_i = 1'b0, rx_byte_valid_i = 1'b0;
  logic [7:0] rx_byte_i = 8'h00;
  logic rx_error_i = 1'b0, rx_end_i = 1'b0, stp_i, got;
  logic dir_o, nxt_o, data_oe_n_o, charge_pump_switch_out_o, supply_fault_o;
  logic [7:0] data_o;
  logic [1:0] bus_line_condition_o, evt = 2'h0, sup = 2'h0, lc = 2'h0;
  logic [8:0] got_data;
  logic [8:0] q[$];
  logic [31:0] seed = 32'h1a;
  int n_errors = 0;
  int samples_checked = 0;
  // Rows: plus/minus pull-downs, speed, termination, mode, lines, squelch, diff, code.
  logic [11:0] rows [18] = '{12'h329, 12'h31a, 12'h33b, 12'h308, 12'h529, 12'h508,
    12'hd29, 12'hd1a, 12'hd08, 12'hf29, 12'h008, 12'h001, 12'h102, 12'h105, 12'h10c,
    12'h882, 12'h888, 12'h801};

  urs_rx_status dut (.clk_i, .rst_i, .transceiver_speed_select_i, .termination_select_i,
    .operating_mode_select_i, .plus_line_pulldown_i, .minus_line_pulldown_i,
    .rising_irq_enable_i, .falling_irq_enable_i, .disconnect_rise_enable_i,
    .disconnect_fall_enable_i, .fault_polarity_bit_i, .external_supply_indicator_sel_i,
    .fault_passthrough_bit_i, .supply_drive_enable_i, .line_plus_i, .line_minus_i, .squelch_i,
    .hs_diff_rx_i, .supply_cmp_i, .ext_fault_i, .id_pin_i, .disconnect_det_i, .sync_det_i,
    .rx_byte_valid_i, .rx_byte_i, .rx_error_i, .rx_end_i, .stp_i, .dir_o, .nxt_o, .data_o,
    .data_oe_n_o, .charge_pump_switch_out_o, .supply_fault_o, .bus_line_condition_o);
  urs_link_model link (.clk_i(clk_i), .rst_i(rst_i), .dir_i(dir_o), .nxt_i(nxt_o),
    .data_i(data_o), .data_oe_n_i(data_oe_n_o), .stp_o(stp_i), .got_o(got),
    .got_data_o(got_data));

  // Free-running clock of 100 ns.
  always #50 clk_i = ~clk_i;

  function automatic logic [31:0] xs32(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs32

  task automatic chk(string what, logic [8:0] seen, logic [8:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Note the status byte the present state should bring.
  task automatic note();
    q.push_back({2'h0, id_pin_i, evt, sup, lc});
  endtask : note

  // Wait, bounded, until every note is matched; then give stray bytes time to show.
  task automatic drain();
    for (int k = 0; k < 40 && q.size() != 0; k++) @(negedge clk_i);
    if (q.size() != 0) begin
      n_errors++;
      wrap_up();
    end
    repeat (10) @(negedge clk_i);
  endtask : drain

  // Every collected byte takes the oldest note; a byte nobody expected meets an unknown.
  always @(posedge clk_i) begin
    if (got) begin
      chk("link byte", got_data, q.size() != 0 ? q.pop_front() : 9'hxxx);
    end
  end

  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    // Both orientations at high and low speed, peripheral full speed and host speed code 3 step through line codes.
    foreach (rows[i]) begin
      {plus_line_pulldown_i, transceiver_speed_select_i, termination_select_i,
        operating_mode_select_i, line_plus_i, line_minus_i, squelch_i, hs_diff_rx_i,
        lc} = rows[i];
      minus_line_pulldown_i = plus_line_pulldown_i;
      note();
      drain();
      chk("line condition", {7'h00, bus_line_condition_o}, {7'h00, lc});
    end
    // Only the enabled rising edge of session valid is reported.
    rising_irq_enable_i = 3'h2;
    supply_cmp_i = 3'h2;
    sup = 2'h2;
    note();
    drain();
    supply_cmp_i = 3'h1;
    sup = 2'h0;
    drain();
    // An A-device link enables both edges and hears every step of the supply.
    rising_irq_enable_i = 3'h6;
    falling_irq_enable_i = 3'h6;
    supply_cmp_i = 3'h6;
    sup = 2'h3;
    note();
    drain();
    supply_cmp_i = 3'h2;
    sup = 2'h2;
    note();
    drain();
    supply_cmp_i = 3'h1;
    sup = 2'h0;
    note();
    drain();
    rising_irq_enable_i = 3'h0;
    falling_irq_enable_i = 3'h0;
    // A peripheral port ignores the disconnect detector, a host reports each edge.
    disconnect_rise_enable_i = 1'b1;
    disconnect_fall_enable_i = 1'b1;
    {plus_line_pulldown_i, minus_line_pulldown_i} = 2'h0;
    for (int d = 0; d < 5; d++) begin
      if (d == 2) begin
        {plus_line_pulldown_i, minus_line_pulldown_i} = 2'h3;
      end
      disconnect_det_i = ~disconnect_det_i;
      evt = (d >= 2 && disconnect_det_i) ? 2'h2 : 2'h0;
      if (d >= 2) begin
        note();
      end
      drain();
    end
    // A packet with an error while a disconnect stands.
    sync_det_i = 1'b1;
    @(negedge clk_i);
    sync_det_i = 1'b0;
    // The first byte may only follow the turn-around cycle.
    @(negedge clk_i);
    seed = xs32(seed);
    rx_byte_i = seed[7:0];
    rx_byte_valid_i = 1'b1;
    q.push_back({1'b1, rx_byte_i});
    @(negedge clk_i);
    rx_byte_valid_i = 1'b0;
    rx_error_i = 1'b1;
    evt = 2'h3;
    note();
    @(negedge clk_i);
    rx_error_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rx_end_i = 1'b1;
    @(negedge clk_i);
    rx_end_i = 1'b0;
    evt = 2'h2;
    note();
    drain();
    // A raw external fault turns the requested charge pump off.
    supply_drive_enable_i = 1'b1;
    external_supply_indicator_sel_i = 1'b1;
    fault_passthrough_bit_i = 1'b1;
    for (int f = 0; f < 2; f++) begin
      ext_fault_i = ~f[0];
      repeat (4) @(negedge clk_i);
      chk("fault", {8'h00, supply_fault_o}, {8'h00, ~f[0]});
      chk("pump", {8'h00, charge_pump_switch_out_o}, {8'h00, f[0]});
    end
    // Without pass-through the fault only counts while A valid is low.
    fault_passthrough_bit_i = 1'b0;
    ext_fault_i = 1'b1;
    supply_cmp_i = 3'h4;
    repeat (4) @(negedge clk_i);
    chk("qualified fault", {8'h00, supply_fault_o}, 9'h000);
    chk("pump", {8'h00, charge_pump_switch_out_o}, 9'h001);
    supply_cmp_i = 3'h1;
    repeat (4) @(negedge clk_i);
    chk("qualified fault", {8'h00, supply_fault_o}, 9'h001);
    chk("pump", {8'h00, charge_pump_switch_out_o}, 9'h000);
    wrap_up();
  end
endmodule : urs_rx_status_tb
